// file: logic/rnf_bank.sv
// Implementation choices: the register addresses and the address-and-strobe port.
`timescale 1ns/1ps
// Notes on behaviour
// - Notches one and two act only while their enable bit is one.
// - Notch three has no enable; it acts whenever its centre is not bypass.
// - A centre value of 5000 makes that notch pass its input untouched.
// - Centre is whole hertz, clamped to 50..5000 on every write.
// - Width is bandwidth over centre in hundredths, 50..1000, reset 70.
// - Bandwidth is taken between the minus 3 dB points around the notch.
// - Depth is centre gain in thousandths, 0..1000; larger means shallower.
// - Depth 0 rejects fully at centre; depth 1000 passes fully.
// - Sweep excitation amplitude comes from the sweep amplitude setting, 1..300.
// - Offline sweep reports the frequency of the largest peak whenever it runs to the end; abort or servo on gives no result.
// - Online identification watches for ten seconds while the machine runs.
// - Online detection uses sensitivity 50..500 and level 0..5000; smaller is keener.
// - Confirm key writes result into the first of notches one and two whose enable is clear, and sets that enable; notch three is never written.
// - Enable bits are single bits, reset zero, taken up by their notch at the next sample strobe.
module rnf_bank #(
  parameter int unsigned SAMPLE_HZ      = rnf_pkg::SAMPLE_HZ_DEF,
  parameter int unsigned SAMPLE_DIV     = rnf_pkg::CLK_HZ / SAMPLE_HZ,
  parameter int unsigned WINDOW_SAMPLES = rnf_pkg::ONLINE_WINDOW_S * SAMPLE_HZ,
  parameter int unsigned GATE_SAMPLES   = SAMPLE_HZ / rnf_pkg::GATE_PER_S,
  parameter int unsigned DWELL_SAMPLES  = rnf_pkg::DWELL_DEF
) (
  // Clock and reset
  input  wire logic               clk_i,
  input  wire logic               arst_n_i,
  // Register port
  input  wire logic [4:0]         addr_i,
  input  wire logic [15:0]        wdata_i,
  input  wire logic               wr_i,
  input  wire logic               rd_i,
  output logic [15:0]             rdata_o,
  // Drive signals
  input  wire logic signed [15:0] torque_i,
  input  wire logic signed [15:0] resp_i,
  input  wire logic signed [15:0] vib_i,
  input  wire logic               servo_on_i,
  input  wire logic               confirm_key_i,
  output logic signed [15:0]      torque_o,
  output logic                    excite_active_o,
  output logic                    sample_o
);

  // Phase step per hertz and F per hertz for the sample rate in use
  localparam longint unsigned PH_K = (64'h1_0000_0000) / SAMPLE_HZ;
  localparam int unsigned     F_K  = int'(6.2831853 * 1048576.0 / real'(SAMPLE_HZ));

  typedef struct packed {
    logic [1:0]            en_sel;
    logic [2:0][15:0]      ctr;
    logic [2:0][15:0]      wid;
    logic [2:0][15:0]      dep;
    logic [15:0]           amp;
    logic [15:0]           sens;
    logic [15:0]           lvl;
    logic [31:0]           div_cnt;
    logic                  smp;
    rnf_pkg::rnf_mode_t    mode;
    logic [15:0]           freq;
    logic [31:0]           cnt;
    logic [31:0]           win;
    logic [15:0]           xings;
    logic                  sgn;
    logic [15:0]           peak;
    logic [15:0]           best_peak;
    logic [15:0]           best_freq;
    logic                  valid;
    logic [31:0]           phase;
    logic signed [15:0]    torque;
    logic [15:0]           rdata;
    logic [2:0]            key;
  } rnf_state_t;

  rnf_state_t         s_q, s_d;
  logic               start_off, start_on, abort_id, key_edge;
  logic [15:0]        mag, pk, tgt_freq;
  logic [31:0]        thresh;
  logic [2:0]         act;
  logic signed [15:0] chain [0:3];

  function automatic logic [23:0] f_coef(input logic [15:0] c);
    return 24'(32'(c) * F_K);
  endfunction

  // Damping equals the width ratio, so the band edges sit at the 3 dB points
  // Wide notches at high centres need F*(F+2*damping) below 4 or the section diverges
  function automatic logic [11:0] q_coef(input logic [15:0] w);
    return 12'((32'(w) * rnf_pkg::D_SCALE) >> rnf_pkg::Q_FRAC);
  endfunction

  function automatic logic [11:0] g_coef(input logic [15:0] d);
    return 12'((32'(rnf_pkg::DEP_MAX - d) * rnf_pkg::Q_SCALE) >> rnf_pkg::Q_FRAC);
  endfunction

  // Section activity from live settings
  always_comb begin
    act[0] = s_q.en_sel[0] && (s_q.ctr[0] != rnf_pkg::CTR_MAX);
    act[1] = s_q.en_sel[1] && (s_q.ctr[1] != rnf_pkg::CTR_MAX);
    act[2] = (s_q.ctr[2] != rnf_pkg::CTR_MAX);
  end

  // Cascade of three sections on the torque command
  assign chain[0] = torque_i;
  for (genvar n = 0; n < 3; n++) begin : g_notch
    rnf_notch u_notch (
      .clk_i    (clk_i),
      .arst_n_i (arst_n_i),
      .step_i   (s_q.smp),
      .active_i (act[n]),
      .f_coef_i (f_coef(s_q.ctr[n])),
      .q_coef_i (q_coef(s_q.wid[n])),
      .g_coef_i (g_coef(s_q.dep[n])),
      .x_i      (chain[n]),
      .y_o      (chain[n+1])
    );
  end

  // Next state
  always_comb begin
    s_d       = s_q;
    s_d.rdata = '0;
    s_d.key   = {s_q.key[1:0], confirm_key_i};
    key_edge  = s_q.key[1] && !s_q.key[2];
    start_off = 1'b0;
    start_on  = 1'b0;
    abort_id  = 1'b0;
    mag       = '0;
    pk        = '0;
    tgt_freq  = rnf_pkg::clamp16(s_q.best_freq, rnf_pkg::CTR_MIN, 16'(rnf_pkg::CTR_MAX - 16'h0001));
    // Smaller level or sensitivity lowers the bar for a detection
    thresh    = (32'(s_q.lvl) * 32'(s_q.sens)) >> rnf_pkg::THR_SHIFT;

    // Sample strobe divider
    s_d.smp = 1'b0;
    if (s_q.div_cnt == 32'(SAMPLE_DIV - 1)) begin
      s_d.div_cnt = '0;
      s_d.smp     = 1'b1;
    end else begin
      s_d.div_cnt = s_q.div_cnt + 32'h1;
    end

    // Register read, data stand for one cycle only
    if (rd_i) begin
      case (addr_i)
        rnf_pkg::A_EN_SEL: s_d.rdata = {14'h0, s_q.en_sel};
        rnf_pkg::A_AMP:    s_d.rdata = s_q.amp;
        rnf_pkg::A_SENS:   s_d.rdata = s_q.sens;
        rnf_pkg::A_LVL:    s_d.rdata = s_q.lvl;
        rnf_pkg::A_STAT:   s_d.rdata = {13'h0, s_q.valid, s_q.mode == rnf_pkg::MODE_ONLINE,
                                        s_q.mode == rnf_pkg::MODE_OFFLINE};
        rnf_pkg::A_RES:    s_d.rdata = s_q.best_freq;
        default:           s_d.rdata = 16'h0;
      endcase
      for (int n = 0; n < 3; n++) begin
        if (addr_i == rnf_pkg::ctr_addr(n)) s_d.rdata = s_q.ctr[n];
        if (addr_i == rnf_pkg::ctr_addr(n) + 5'h01) s_d.rdata = s_q.wid[n];
        if (addr_i == rnf_pkg::ctr_addr(n) + 5'h02) s_d.rdata = s_q.dep[n];
      end
    end

    // Register write, every setting but the enable bits clamped into its legal range; enable bits take the low two bits
    if (wr_i) begin
      case (addr_i)
        rnf_pkg::A_EN_SEL: s_d.en_sel = wdata_i[1:0];
        rnf_pkg::A_AMP:    s_d.amp = rnf_pkg::clamp16(wdata_i, rnf_pkg::AMP_MIN, rnf_pkg::AMP_MAX);
        rnf_pkg::A_SENS:   s_d.sens = rnf_pkg::clamp16(wdata_i, rnf_pkg::SENS_MIN, rnf_pkg::SENS_MAX);
        rnf_pkg::A_LVL:    s_d.lvl = rnf_pkg::clamp16(wdata_i, 16'h0000, rnf_pkg::LVL_MAX);
        rnf_pkg::A_CMD: begin
          start_off = wdata_i[rnf_pkg::CMD_OFFLINE];
          start_on  = wdata_i[rnf_pkg::CMD_ONLINE];
          abort_id  = wdata_i[rnf_pkg::CMD_ABORT];
        end
        default: ;
      endcase
      for (int n = 0; n < 3; n++) begin
        if (addr_i == rnf_pkg::ctr_addr(n))
          s_d.ctr[n] = rnf_pkg::clamp16(wdata_i, rnf_pkg::CTR_MIN, rnf_pkg::CTR_MAX);
        if (addr_i == rnf_pkg::ctr_addr(n) + 5'h01)
          s_d.wid[n] = rnf_pkg::clamp16(wdata_i, rnf_pkg::WID_MIN, rnf_pkg::WID_MAX);
        if (addr_i == rnf_pkg::ctr_addr(n) + 5'h02)
          s_d.dep[n] = rnf_pkg::clamp16(wdata_i, 16'h0000, rnf_pkg::DEP_MAX);
      end
    end

    // Torque output follows the cascade unless the sweep owns it
    if (s_q.smp && s_q.mode != rnf_pkg::MODE_OFFLINE) s_d.torque = chain[3];

    // Identification sequencer
    unique case (s_q.mode)
      rnf_pkg::MODE_IDLE: begin
        // Sweep is refused while the servo is on; watch is refused while off
        if (start_off && !servo_on_i) begin
          s_d.mode      = rnf_pkg::MODE_OFFLINE;
          s_d.freq      = rnf_pkg::CTR_MIN;
          s_d.cnt       = '0;
          s_d.peak      = '0;
          s_d.best_peak = '0;
          s_d.best_freq = rnf_pkg::CTR_MIN;
          s_d.valid     = 1'b0;
          s_d.phase     = '0;
        end else if (start_on && servo_on_i) begin
          s_d.mode      = rnf_pkg::MODE_ONLINE;
          s_d.cnt       = '0;
          s_d.win       = '0;
          s_d.xings     = '0;
          s_d.peak      = '0;
          s_d.best_peak = '0;
          s_d.sgn       = vib_i[15];
          s_d.valid     = 1'b0;
        end
      end
      rnf_pkg::MODE_OFFLINE: begin
        mag = rnf_pkg::abs16(resp_i);
        pk  = (mag > s_q.peak) ? mag : s_q.peak;
        if (abort_id || servo_on_i) begin
          s_d.mode   = rnf_pkg::MODE_IDLE;
          s_d.torque = '0;
        end else if (s_q.smp) begin
          // Square excitation at the stepping frequency
          s_d.phase  = s_q.phase + 32'(64'(s_q.freq) * PH_K);
          s_d.torque = s_q.phase[31] ? -$signed(s_q.amp) : $signed(s_q.amp);
          s_d.peak   = pk;
          s_d.cnt    = s_q.cnt + 32'h1;
          if (s_q.cnt == 32'(DWELL_SAMPLES - 1)) begin
            s_d.cnt  = '0;
            s_d.peak = '0;
            if (pk > s_q.best_peak) begin
              s_d.best_peak = pk;
              s_d.best_freq = s_q.freq;
            end
            if (s_q.freq >= 16'(rnf_pkg::CTR_MAX - rnf_pkg::FREQ_STEP)) begin
              // A result is given even when no real resonance exists
              s_d.mode   = rnf_pkg::MODE_IDLE;
              s_d.valid  = 1'b1;
              s_d.torque = '0;
            end else begin
              s_d.freq = s_q.freq + rnf_pkg::FREQ_STEP;
            end
          end
        end
      end
      rnf_pkg::MODE_ONLINE: begin
        mag = rnf_pkg::abs16(vib_i);
        pk  = (mag > s_q.peak) ? mag : s_q.peak;
        if (abort_id) begin
          s_d.mode = rnf_pkg::MODE_IDLE;
        end else if (s_q.smp) begin
          // Sign changes over a half-second gate equal the frequency in hertz
          s_d.sgn   = vib_i[15];
          s_d.xings = s_q.xings + {15'h0, vib_i[15] != s_q.sgn};
          s_d.peak  = pk;
          s_d.cnt   = s_q.cnt + 32'h1;
          s_d.win   = s_q.win + 32'h1;
          if (s_q.cnt == 32'(GATE_SAMPLES - 1)) begin
            s_d.cnt   = '0;
            s_d.peak  = '0;
            s_d.xings = '0;
            if (32'(pk) >= thresh && pk > s_q.best_peak) begin
              s_d.best_peak = pk;
              s_d.best_freq = s_q.xings;
              s_d.valid     = 1'b1;
            end
          end
          if (s_q.win == 32'(WINDOW_SAMPLES - 1)) s_d.mode = rnf_pkg::MODE_IDLE;
        end
      end
    endcase

    // Confirm key after the write path, so hardware setting wins a race
    if (key_edge && s_q.valid && s_q.mode == rnf_pkg::MODE_IDLE) begin
      if (!s_d.en_sel[0]) begin
        s_d.ctr[0]    = tgt_freq;
        s_d.en_sel[0] = 1'b1;
      end else if (!s_d.en_sel[1]) begin
        s_d.ctr[1]    = tgt_freq;
        s_d.en_sel[1] = 1'b1;
      end
    end
  end

  // State register with factory settings
  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      s_q      <= '0;
      s_q.ctr  <= {3{rnf_pkg::CTR_RST}};
      s_q.wid  <= {3{rnf_pkg::WID_RST}};
      s_q.dep  <= {3{rnf_pkg::DEP_RST}};
      s_q.amp  <= rnf_pkg::AMP_RST;
      s_q.sens <= rnf_pkg::SENS_RST;
      s_q.lvl  <= rnf_pkg::LVL_RST;
      s_q.mode <= rnf_pkg::MODE_IDLE;
      s_q.freq <= rnf_pkg::CTR_MIN;
    end else begin
      s_q <= s_d;
    end
  end

  assign rdata_o         = s_q.rdata;
  assign torque_o        = s_q.torque;
  assign excite_active_o = (s_q.mode == rnf_pkg::MODE_OFFLINE);
  assign sample_o        = s_q.smp;

  // Checks beside the control logic; the data path is checked inside each section
  notch_gate_a: assert property (@(posedge clk_i) disable iff (!arst_n_i)
    act[0] |-> s_q.en_sel[0]) else $error("notch one active with enable clear");
  third_active_a: assert property (@(posedge clk_i) disable iff (!arst_n_i)
    act[2] == (s_q.ctr[2] != rnf_pkg::CTR_MAX)) else $error("notch three activity wrong");
  centre_range_a: assert property (@(posedge clk_i) disable iff (!arst_n_i)
    s_q.ctr[0] >= rnf_pkg::CTR_MIN && s_q.ctr[0] <= rnf_pkg::CTR_MAX) else $error("centre out of range");
  width_range_a: assert property (@(posedge clk_i) disable iff (!arst_n_i)
    s_q.wid[1] >= rnf_pkg::WID_MIN && s_q.wid[1] <= rnf_pkg::WID_MAX) else $error("width out of range");
  depth_write_a: assert property (@(posedge clk_i) disable iff (!arst_n_i)
    wr_i && addr_i == rnf_pkg::ctr_addr(0) + 5'h02 && wdata_i > rnf_pkg::DEP_MAX |=> s_q.dep[0] == rnf_pkg::DEP_MAX)
    else $error("depth not clamped");
  excite_amp_a: assert property (@(posedge clk_i) disable iff (!arst_n_i)
    s_q.mode == rnf_pkg::MODE_OFFLINE && s_q.smp && !servo_on_i && !abort_id && s_q.cnt == 32'h0
    |=> s_q.torque == $signed($past(s_q.amp)) || s_q.torque == -$signed($past(s_q.amp)))
    else $error("excitation amplitude wrong");
  sweep_servo_a: assert property (@(posedge clk_i) disable iff (!arst_n_i)
    s_q.mode == rnf_pkg::MODE_OFFLINE && servo_on_i |=> s_q.mode == rnf_pkg::MODE_IDLE)
    else $error("sweep continued with servo on");
  window_len_a: assert property (@(posedge clk_i) disable iff (!arst_n_i)
    s_q.mode == rnf_pkg::MODE_ONLINE |-> s_q.win < 32'(WINDOW_SAMPLES)) else $error("online window overran");
  confirm_set_a: assert property (@(posedge clk_i) disable iff (!arst_n_i)
    key_edge && s_q.valid && s_q.mode == rnf_pkg::MODE_IDLE && !s_q.en_sel[0] && !wr_i
    |=> s_q.en_sel[0] && s_q.ctr[0] == $past(tgt_freq)) else $error("confirm did not load notch one");
  strobe_single_a: assert property (@(posedge clk_i) disable iff (!arst_n_i)
    s_q.smp |=> !s_q.smp) else $error("sample strobe longer than one cycle");

  sweep_done_c: cover property (@(posedge clk_i) disable iff (!arst_n_i)
    s_q.mode == rnf_pkg::MODE_OFFLINE ##1 s_q.mode == rnf_pkg::MODE_IDLE && s_q.valid);
  online_hit_c: cover property (@(posedge clk_i) disable iff (!arst_n_i)
    s_q.mode == rnf_pkg::MODE_ONLINE && $rose(s_q.valid));
  confirm_c: cover property (@(posedge clk_i) disable iff (!arst_n_i)
    $rose(s_q.en_sel[1]) && !wr_i);
  sweep_abort_c: cover property (@(posedge clk_i) disable iff (!arst_n_i)
    s_q.mode == rnf_pkg::MODE_OFFLINE && abort_id);
  confirm_full_c: cover property (@(posedge clk_i) disable iff (!arst_n_i)
    key_edge && s_q.valid && s_q.en_sel == 2'b11);

endmodule // rnf_bank

// file: logic/rnf_notch.sv
`timescale 1ns/1ps
module rnf_notch (
  // Clock and reset
  input  wire logic               clk_i,
  input  wire logic               arst_n_i,
  // Sample strobe and settings
  input  wire logic               step_i,
  input  wire logic               active_i,
  input  wire logic [23:0]        f_coef_i,
  input  wire logic [11:0]        q_coef_i,
  input  wire logic [11:0]        g_coef_i,
  // Signal path
  input  wire logic signed [15:0] x_i,
  output logic signed [15:0]      y_o
);

  typedef struct packed {
    logic signed [31:0] lp;
    logic signed [31:0] bp;
    logic signed [15:0] y;
    logic [23:0]        f;
    logic [11:0]        q;
    logic [11:0]        g;
    logic               act;
  } rnf_notch_st_t;

  rnf_notch_st_t      s_q, s_d;
  logic signed [63:0] xs, lp_n, qbp, hp, bp_n, out;

  // State variable section: band output scaled by damping has unit gain at centre
  always_comb begin
    s_d  = s_q;
    xs   = 64'(x_i) <<< 8;
    lp_n = 64'(s_q.lp) + ((64'(s_q.bp) * $signed({40'h0, s_q.f})) >>> rnf_pkg::F_FRAC);
    qbp  = (64'(s_q.bp) * $signed({52'h0, s_q.q})) >>> rnf_pkg::D_FRAC;
    hp   = xs - lp_n - qbp;
    bp_n = 64'(s_q.bp) + ((hp * $signed({40'h0, s_q.f})) >>> rnf_pkg::F_FRAC);
    out  = xs - ((qbp * $signed({52'h0, s_q.g})) >>> rnf_pkg::Q_FRAC);
    if (step_i) begin
      // New settings only take hold at a sample edge, no mid-sample mix
      s_d.f   = f_coef_i;
      s_d.q   = q_coef_i;
      s_d.g   = g_coef_i;
      s_d.act = active_i;
      if (!s_q.act) begin
        // Bypass flushes the state so a later enable starts clean
        s_d.lp = '0;
        s_d.bp = '0;
        s_d.y  = x_i;
      end else begin
        s_d.lp = 32'(lp_n);
        s_d.bp = 32'(bp_n);
        s_d.y  = rnf_pkg::sat16(out >>> 8);
      end
    end
  end

  // State register
  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  assign y_o = s_q.y;

  bypass_pass_a: assert property (@(posedge clk_i) disable iff (!arst_n_i)
    step_i && !s_q.act |=> y_o == $past(x_i)) else $error("bypassed notch altered its input");

endmodule // rnf_notch

// file: logic/rnf_pkg.sv
package rnf_pkg;

  // Clock and timing
  localparam int unsigned CLK_PERIOD_NS   = 10;
  localparam int unsigned CLK_HZ          = 1000000000 / CLK_PERIOD_NS;
  localparam int unsigned SAMPLE_HZ_DEF   = 10000;
  localparam int unsigned ONLINE_WINDOW_S = 10;
  localparam int unsigned GATE_PER_S      = 2;
  localparam int unsigned DWELL_DEF       = 200;

  // Register indices
  localparam logic [4:0] A_EN_SEL = 5'h00;
  localparam logic [4:0] A_CTR1   = 5'h01;
  localparam logic [4:0] A_AMP    = 5'h0a;
  localparam logic [4:0] A_SENS   = 5'h0b;
  localparam logic [4:0] A_LVL    = 5'h0c;
  localparam logic [4:0] A_CMD    = 5'h0d;
  localparam logic [4:0] A_STAT   = 5'h0e;
  localparam logic [4:0] A_RES    = 5'h0f;

  // Command and status bits
  localparam int CMD_OFFLINE = 0;
  localparam int CMD_ONLINE  = 1;
  localparam int CMD_ABORT   = 2;
  localparam int ST_OFFLINE  = 0;
  localparam int ST_ONLINE   = 1;
  localparam int ST_VALID    = 2;

  // Ranges and reset values
  localparam logic [15:0] CTR_MIN  = 16'h0032;
  localparam logic [15:0] CTR_MAX  = 16'h1388;
  localparam logic [15:0] CTR_RST  = 16'h1388;
  localparam logic [15:0] WID_MIN  = 16'h0032;
  localparam logic [15:0] WID_MAX  = 16'h03e8;
  localparam logic [15:0] WID_RST  = 16'h0046;
  localparam logic [15:0] DEP_MAX  = 16'h03e8;
  localparam logic [15:0] DEP_RST  = 16'h0000;
  localparam logic [15:0] AMP_MIN  = 16'h0001;
  localparam logic [15:0] AMP_MAX  = 16'h012c;
  localparam logic [15:0] AMP_RST  = 16'h0064;
  localparam logic [15:0] SENS_MIN = 16'h0032;
  localparam logic [15:0] SENS_MAX = 16'h01f4;
  localparam logic [15:0] SENS_RST = 16'h0064;
  localparam logic [15:0] LVL_MAX  = 16'h1388;
  localparam logic [15:0] LVL_RST  = 16'h03e8;
  localparam logic [15:0] FREQ_STEP = 16'h000a;

  // Fixed point: F in Q20, gain in Q10, 1.024 as 1049/1024
  localparam int F_FRAC  = 20;
  localparam int Q_FRAC  = 10;
  localparam int Q_SCALE = 1049;
  localparam int THR_SHIFT = 6;
  // Width hundredths to damping in Q8, 2.56 as 2621/1024, so width 1000 still fits 12 bits
  localparam int D_FRAC  = 8;
  localparam int D_SCALE = 2621;

  typedef enum logic [2:0] {
    MODE_IDLE    = 3'b001,
    MODE_OFFLINE = 3'b010,
    MODE_ONLINE  = 3'b100
  } rnf_mode_t;

  function automatic logic [15:0] clamp16(input logic [15:0] v, input logic [15:0] lo, input logic [15:0] hi);
    return (v < lo) ? lo : ((v > hi) ? hi : v);
  endfunction

  function automatic logic signed [15:0] sat16(input logic signed [63:0] v);
    if (v > 64'sh7fff) return 16'sh7fff;
    if (v < -64'sh8000) return 16'sh8000;
    return v[15:0];
  endfunction

  function automatic logic [15:0] abs16(input logic signed [15:0] v);
    return v[15] ? 16'(-v) : v;
  endfunction

  function automatic logic [4:0] ctr_addr(input int n);
    return 5'(int'(A_CTR1) + 3 * n);
  endfunction

endpackage

// file: verif/tb_rnf_bank.sv
`timescale 1ns/1ps
module tb_rnf_bank;
  // Bench-driven signals, all given a value at time zero
  logic               clk_i         = 1'b0;
  logic               arst_n_i      = 1'b0;
  logic [4:0]         addr_i        = 5'h00;
  logic [15:0]        wdata_i       = 16'h0000;
  logic               wr_i          = 1'b0;
  logic               rd_i          = 1'b0;
  logic [15:0]        rdata_o;
  logic signed [15:0] torque_i      = 16'sh0000;
  logic signed [15:0] resp_i        = 16'sh0000;
  logic signed [15:0] vib_i         = 16'sh4000;
  logic               servo_on_i    = 1'b1;
  logic               confirm_key_i = 1'b0;
  logic signed [15:0] torque_o;
  logic               excite_active_o;
  logic               sample_o;
  int                 fails         = 0;
  int                 compares      = 0;

  // 100 MHz clock
  always #5 clk_i = ~clk_i;

  // Motor echoes the command, so no sweep step sees a larger peak than the first
  always @(posedge clk_i) resp_i <= torque_o;
  // Vibration flips sign every sample
  always @(posedge clk_i) if (sample_o) vib_i <= -vib_i;

  // Short counts keep the sweep and window within a few thousand clocks
  rnf_bank #(.SAMPLE_DIV(4), .WINDOW_SAMPLES(40), .GATE_SAMPLES(10), .DWELL_SAMPLES(2)) dut (
    .clk_i(clk_i), .arst_n_i(arst_n_i), .addr_i(addr_i), .wdata_i(wdata_i), .wr_i(wr_i),
    .rd_i(rd_i), .rdata_o(rdata_o), .torque_i(torque_i), .resp_i(resp_i), .vib_i(vib_i),
    .servo_on_i(servo_on_i), .confirm_key_i(confirm_key_i), .torque_o(torque_o),
    .excite_active_o(excite_active_o), .sample_o(sample_o));

  // Verdict and end of run
  task automatic complete_run();
    $display("compares=%0d fails=%0d", compares, fails);
    if (fails == 0 && compares > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask

  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    compares++;
    if (got !== exp) begin
      fails++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic cyc(input int n);
    repeat (n) @(posedge clk_i);
  endtask

  // One-cycle write strobe
  task automatic wr(input logic [4:0] a, input logic [15:0] d);
    @(posedge clk_i);
    addr_i  <= a;
    wdata_i <= d;
    wr_i    <= 1'b1;
    @(posedge clk_i);
    wr_i    <= 1'b0;
  endtask

  // Read data stand only in the cycle after the strobe
  task automatic rd(input logic [4:0] a, output logic [15:0] v);
    @(posedge clk_i);
    addr_i <= a;
    rd_i   <= 1'b1;
    @(posedge clk_i);
    rd_i   <= 1'b0;
    #1 v = rdata_o;
  endtask

  task automatic rchk(input logic [4:0] a, input logic [15:0] e);
    logic [15:0] v;
    rd(a, v);
    chk(v, e);
  endtask

  // Long press held well past the two-flop synchroniser
  task automatic press();
    @(posedge clk_i);
    confirm_key_i <= 1'b1;
    cyc(6);
    confirm_key_i <= 1'b0;
    cyc(6);
  endtask

  // Reset values, index 0x00..0x0e; addr, written value, clamped read-back
  logic [15:0] rst_v [15] = '{16'h0000, 16'h1388, 16'h0046, 16'h0000, 16'h1388, 16'h0046, 16'h0000,
                              16'h1388, 16'h0046, 16'h0000, 16'h0064, 16'h0064, 16'h03e8, 16'h0000, 16'h0000};
  logic [36:0] clamp_t [10] = '{{5'h01, 16'h000a, 16'h0032}, {5'h01, 16'h1770, 16'h1388},
                                {5'h02, 16'h0014, 16'h0032}, {5'h02, 16'h07d0, 16'h03e8},
                                {5'h03, 16'h07d0, 16'h03e8}, {5'h0a, 16'h0000, 16'h0001},
                                {5'h0a, 16'h0190, 16'h012c}, {5'h0b, 16'h000a, 16'h0032},
                                {5'h0c, 16'h1770, 16'h1388}, {5'h00, 16'hffff, 16'h0003}};

  initial begin
    int          i;
    logic [15:0] v;
    cyc(12);
    arst_n_i <= 1'b1;
    for (i = 0; i < 15; i++) rchk(5'(i), rst_v[i]);
    rchk(5'h10, 16'h0000);
    // One strobe every four clocks with the shortened divider
    v = 16'h0000;
    repeat (40) begin
      @(posedge clk_i);
      #1 v = v + 16'(sample_o);
    end
    chk(v, 16'h000a);
    // Out-of-range values are clamped, not refused
    for (i = 0; i < 10; i++) begin
      wr(clamp_t[i][36:32], clamp_t[i][31:16]);
      rchk(clamp_t[i][36:32], clamp_t[i][15:0]);
    end
    // Valid centre but enable clear, third centre at bypass: exact pass-through
    wr(5'h00, 16'h0000);
    wr(5'h01, 16'h03e8);
    @(posedge clk_i);
    torque_i <= 16'sh1234;
    cyc(40);
    chk(torque_o, 16'h1234);
    torque_i <= -16'sh2000;
    cyc(40);
    chk(torque_o, 16'he000);
    // Sweep refused while the servo is on
    wr(5'h0d, 16'h0001);
    rchk(5'h0e, 16'h0000);
    // Online with the coarsest setting finds nothing
    wr(5'h0b, 16'h01f4);
    wr(5'h0c, 16'h1388);
    wr(5'h0d, 16'h0002);
    cyc(130);
    rd(5'h0e, v);
    chk({15'h0000, v[1]}, 16'h0001);
    cyc(200);
    rchk(5'h0e, 16'h0000);
    // Keenest level finds the vibration
    wr(5'h0c, 16'h0000);
    wr(5'h0d, 16'h0002);
    cyc(330);
    rchk(5'h0e, 16'h0004);
    // Offline sweep at the top amplitude with the servo off
    @(posedge clk_i);
    servo_on_i <= 1'b0;
    // A start clears the old result and abort ends the sweep at once
    wr(5'h0d, 16'h0001);
    wr(5'h0d, 16'h0004);
    rchk(5'h0e, 16'h0000);
    wr(5'h0d, 16'h0001);
    cyc(50);
    rchk(5'h0e, 16'h0001);
    chk({15'h0000, excite_active_o}, 16'h0001);
    chk(torque_o[15] ? 16'(-torque_o) : torque_o, 16'h012c);
    for (i = 0; i < 8000 && excite_active_o !== 1'b0; i++) @(posedge clk_i);
    // A sweep that never ends counts as a mismatch and skips the rest
    if (i == 8000) begin
      fails++;
    end else begin
      rchk(5'h0e, 16'h0004);
      rchk(5'h0f, 16'h0032);
      // Confirm fills notch one, then two, then nothing
      press();
      rchk(5'h00, 16'h0001);
      rchk(5'h01, 16'h0032);
      press();
      rchk(5'h00, 16'h0003);
      rchk(5'h04, 16'h0032);
      press();
      rchk(5'h00, 16'h0003);
      rchk(5'h07, 16'h1388);
    end
    complete_run();
  end
endmodule // tb_rnf_bank
